/* dca_ar_file.sv */
`timescale 1ns/1ps
module dca_ar_file
  import dca_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // access
  dca_ar_if.file ar
);
  logic [HALF_W-1:0] mem_q [AR_N];
  logic [HALF_W-1:0] mem_d [AR_N];
  logic [HALF_W-1:0] rd_q, rd_d, idx_q, idx_d;

  // ===========================================
  // eight entries, write-through read
  always_comb begin
    for (int i = 0; i < AR_N; i++) begin
      mem_d[i] = (ar.wr_en && ar.wr_sel == ARP_W'(i)) ? ar.wr_data : mem_q[i];
    end
    rd_d = mem_d[ar.rd_sel];
    idx_d = mem_d[IDX_AR];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < AR_N; i++) mem_q[i] <= AR_RST;
      rd_q <= AR_RST;
      idx_q <= AR_RST;
    end else if (ce) begin
      mem_q <= mem_d;
      rd_q <= rd_d;
      idx_q <= idx_d;
    end
  end

  assign ar.rd_data = rd_q;
  assign ar.idx_data = idx_q;
endmodule // dca_ar_file

/* dca_ar_if.sv */
`timescale 1ns/1ps
interface dca_ar_if;
  import dca_pkg::*;
  logic wr_en;
  logic [ARP_W-1:0] wr_sel;
  logic [HALF_W-1:0] wr_data;
  logic [ARP_W-1:0] rd_sel;
  logic [HALF_W-1:0] rd_data;
  logic [HALF_W-1:0] idx_data;
  modport core (output wr_en, output wr_sel, output wr_data, output rd_sel,
    input rd_data, input idx_data);
  modport file (input wr_en, input wr_sel, input wr_data, input rd_sel,
    output rd_data, output idx_data);
endinterface

/* dca_datapath.sv */
`timescale 1ns/1ps
// Notes on behaviour
// RL1: carry follows arithmetic and shifts, not logic
// RL2: add/sub with carry use old carry
// RL3: high-half add only sets carry
// RL4: high-half subtract only clears carry
// RL5: carry conditions; set, clear, status load
// RL6: carry is one after reset
// RL7: 32-bit accumulator, stored as halves
// RL8: store shifter 0..7, accumulator untouched
// RL9: high store fills from low half
// RL10: low store fills zeros
// RL11: one-bit shift/rotate exits into carry
// RL12: right shift arithmetic when sign extension set
// RL13: left shift ignores sign extension
// RL14: repeat prefix repeats shifts and rotates
// RL15: eight 16-bit auxiliary registers
// RL16: 3-bit pointer selects current register
// RL17: aux loads from memory, acc, product, immediate
// RL18: address unit post-modifies current register
// RL19: rotate brings old carry into vacancy
module dca_datapath
  import dca_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // accumulator operation
  input wire logic op_valid,
  input wire dca_op_t op,
  input wire logic [ACC_W-1:0] operand,
  input wire logic sign_ext_mode,
  input wire logic status_carry,
  input wire logic [7:0] repeat_count,
  output logic busy,
  // carry condition
  input wire dca_cond_t cond_sel,
  output logic cond_true,
  output logic carry,
  // accumulator store
  input wire logic store_high,
  input wire logic [SHF_W-1:0] store_shift,
  output logic [HALF_W-1:0] store_data,
  output logic [ACC_W-1:0] acc,
  // auxiliary registers
  input wire logic ar_load,
  input wire logic arp_load,
  input wire dca_src_t ar_src,
  input wire logic [HALF_W-1:0] mem_data,
  input wire logic [ACC_W-1:0] prod_data,
  input wire logic [HALF_W-1:0] imm_data,
  input wire logic [ARP_W-1:0] ar_sel,
  input wire logic addr_valid,
  input wire dca_mod_t addr_mod,
  output logic [HALF_W-1:0] addr,
  output logic [ARP_W-1:0] aux_pointer,
  output logic [HALF_W-1:0] ar_out
);
  dca_ar_if ar_bus();

  dca_ar_file u_ar_file (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .ar(ar_bus)
  );

  // ===========================================
  // accumulator and carry
  logic [ACC_W-1:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic [7:0] rpt_q, rpt_d;
  logic busy_q, busy_d;
  dca_op_t rop_q, rop_d;
  logic [ACC_W:0] sum;
  dca_op_t cur_op;
  logic cur_valid;

  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    rpt_d = rpt_q;
    rop_d = rop_q;
    sum = '0;
    cur_op = op;
    cur_valid = op_valid;
    if (rpt_q != 8'h00) begin
      cur_op = rop_q;
      cur_valid = 1'b1;
      rpt_d = rpt_q - 8'h01;
    // RL14: repeat prefix latch
    end else if (op_valid && repeat_count != 8'h00 &&
        (op == OP_SHL || op == OP_SHR || op == OP_ROL || op == OP_ROR)) begin
      rpt_d = repeat_count;
      rop_d = op;
    end
    busy_d = rpt_d != 8'h00;
    if (cur_valid) begin
      unique case (cur_op)
        // RL1: loads leave carry
        OP_LOAD: acc_d = operand;
        OP_ADD: begin
          sum = {1'b0, acc_q} + {1'b0, operand};
          {carry_d, acc_d} = sum;
        end
        OP_SUB: begin
          sum = {1'b0, acc_q} - {1'b0, operand};
          acc_d = sum[ACC_W-1:0];
          carry_d = ~sum[ACC_W];
        end
        // RL2: previous carry included
        OP_ADD_C: begin
          sum = {1'b0, acc_q} + {1'b0, operand} + {{ACC_W{1'b0}}, carry_q};
          {carry_d, acc_d} = sum;
        end
        OP_SUB_B: begin
          sum = {1'b0, acc_q} - {1'b0, operand} - {{ACC_W{1'b0}}, ~carry_q};
          acc_d = sum[ACC_W-1:0];
          carry_d = ~sum[ACC_W];
        end
        // RL3: set only on carry
        OP_ADD_HI: begin
          sum = {1'b0, acc_q} + {1'b0, operand[HALF_W-1:0], {HALF_W{1'b0}}};
          acc_d = sum[ACC_W-1:0];
          if (sum[ACC_W]) carry_d = 1'b1;
        end
        // RL4: clear only on borrow
        OP_SUB_HI: begin
          sum = {1'b0, acc_q} - {1'b0, operand[HALF_W-1:0], {HALF_W{1'b0}}};
          acc_d = sum[ACC_W-1:0];
          if (sum[ACC_W]) carry_d = 1'b0;
        end
        OP_AND: acc_d = acc_q & operand;
        OP_OR: acc_d = acc_q | operand;
        OP_XOR: acc_d = acc_q ^ operand;
        // RL13: zero into bit 0
        // RL11: exit bit to carry
        OP_SHL: {carry_d, acc_d} = {acc_q, 1'b0};
        // RL12: sign or zero in
        OP_SHR: {acc_d, carry_d} = {sign_ext_mode & acc_q[ACC_W-1], acc_q};
        // RL19: old carry to vacancy
        OP_ROL: {carry_d, acc_d} = {acc_q, carry_q};
        OP_ROR: {acc_d, carry_d} = {carry_q, acc_q};
        // RL5: software carry writes
        OP_SET_C: carry_d = 1'b1;
        OP_CLR_C: carry_d = 1'b0;
        OP_LD_ST: carry_d = status_carry;
        OP_NOP: ;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= '0;
      // RL6: reset carry high
      carry_q <= CARRY_RST;
      rpt_q <= 8'h00;
      rop_q <= OP_NOP;
      busy_q <= 1'b0;
    end else if (ce) begin
      // RL7: registered result
      acc_q <= acc_d;
      carry_q <= carry_d;
      rpt_q <= rpt_d;
      rop_q <= rop_d;
      busy_q <= busy_d;
    end
  end

  // ===========================================
  // store shifter and condition outputs
  logic [HALF_W-1:0] store_q, store_d;
  logic [ACC_W-1:0] shifted;
  logic cond_q, cond_d;

  always_comb begin
    shifted = acc_q << store_shift;
    // RL8: bus path only
    // RL9: low bits from low half
    // RL10: zero-filled low store
    store_d = store_high ? shifted[ACC_W-1:HALF_W] : shifted[HALF_W-1:0];
    // RL5: carry conditions
    unique case (cond_sel)
      CND_ALWAYS: cond_d = 1'b1;
      CND_CARRY: cond_d = carry_d;
      CND_NO_CARRY: cond_d = ~carry_d;
      CND_NEVER: cond_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      store_q <= '0;
      cond_q <= 1'b0;
    end else if (ce) begin
      store_q <= store_d;
      cond_q <= cond_d;
    end
  end

  // ===========================================
  // auxiliary pointer and address unit
  logic [ARP_W-1:0] arp_q, arp_d;
  logic [HALF_W-1:0] addr_q, addr_d, src_val;

  always_comb begin
    // RL17: load sources
    unique case (ar_src)
      SRC_MEM: src_val = mem_data;
      SRC_ACC: src_val = acc_q[HALF_W-1:0];
      SRC_PROD: src_val = prod_data[HALF_W-1:0];
      SRC_IMM: src_val = imm_data;
    endcase
    arp_d = arp_q;
    // RL16: pointer load
    if (arp_load) arp_d = src_val[ARP_W-1:0];
    addr_d = addr_q;
    ar_bus.wr_en = 1'b0;
    ar_bus.wr_sel = ar_sel;
    ar_bus.wr_data = src_val;
    // RL15: current register read
    ar_bus.rd_sel = arp_d;
    if (ar_load) begin
      ar_bus.wr_en = 1'b1;
    end else if (addr_valid) begin
      addr_d = ar_bus.rd_data;
      ar_bus.wr_sel = arp_q;
      ar_bus.wr_en = addr_mod != MOD_NONE;
      // RL18: post-modify without alu
      unique case (addr_mod)
        MOD_NONE: ar_bus.wr_data = ar_bus.rd_data;
        MOD_INC: ar_bus.wr_data = ar_bus.rd_data + 16'h0001;
        MOD_DEC: ar_bus.wr_data = ar_bus.rd_data - 16'h0001;
        MOD_IDX: ar_bus.wr_data = ar_bus.rd_data + ar_bus.idx_data;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arp_q <= ARP_RST;
      addr_q <= AR_RST;
    end else if (ce) begin
      arp_q <= arp_d;
      addr_q <= addr_d;
    end
  end

  assign acc = acc_q;
  assign carry = carry_q;
  assign busy = busy_q;
  assign store_data = store_q;
  assign cond_true = cond_q;
  assign aux_pointer = arp_q;
  assign addr = addr_q;
  assign ar_out = ar_bus.rd_data;
endmodule // dca_datapath

/* dca_datapath_asserts.sv */
`timescale 1ns/1ps
module dca_datapath_asserts
  import dca_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // operation
  input wire logic op_valid,
  input wire dca_op_t op,
  input wire logic [ACC_W-1:0] operand,
  input wire logic sign_ext_mode,
  input wire logic [7:0] repeat_count,
  input wire logic busy,
  input wire dca_cond_t cond_sel,
  input wire logic cond_true,
  input wire logic carry,
  // store
  input wire logic [ACC_W-1:0] acc,
  input wire logic store_high,
  input wire logic [SHF_W-1:0] store_shift,
  input wire logic [HALF_W-1:0] store_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  logic [ACC_W-1:0] sh;
  assign tk = ce && op_valid && !busy;
  assign sh = acc << store_shift;
  // ===========================================
  // properties
  // logic keeps carry
  property p_logic;
    tk && op inside {OP_LOAD, OP_AND, OP_OR, OP_XOR} |=> $stable(carry);
  endproperty
  a_logic: assert property (p_logic) else $error("carry moved on logic op");
  property p_add_with_carry_op;
    tk && op == OP_ADD_C |=>
      {carry, acc} == {1'b0, $past(acc)} + {1'b0, $past(operand)} + 33'($past(carry));
  endproperty
  a_add_with_carry_op: assert property (p_add_with_carry_op) else $error("add with carry wrong");
  property p_addhi;
    tk && op == OP_ADD_HI && carry |=> carry;
  endproperty
  a_addhi: assert property (p_addhi) else $error("high add cleared carry");
  property p_subhi;
    tk && op == OP_SUB_HI && !carry |=> !carry;
  endproperty
  a_subhi: assert property (p_subhi) else $error("high sub set carry");
  property p_shr;
    tk && op == OP_SHR |=> acc == {$past(sign_ext_mode && acc[31]), $past(acc[31:1])}
      && carry == $past(acc[0]);
  endproperty
  a_shr: assert property (p_shr) else $error("right shift wrong");
  property p_rol;
    tk && op == OP_ROL |=> acc == {$past(acc[30:0]), $past(carry)} && carry == $past(acc[31]);
  endproperty
  a_rol: assert property (p_rol) else $error("left rotate wrong");
  property p_rep;
    tk && op == OP_SHL && repeat_count == 8'h02 |=> busy [*2] ##1 !busy;
  endproperty
  a_rep: assert property (p_rep) else $error("repeat length wrong");
  property p_cond;
    ce && cond_sel == CND_NO_CARRY |=> cond_true != carry;
  endproperty
  a_cond: assert property (p_cond) else $error("no carry condition wrong");
  property p_store;
    ce && !op_valid && !busy |=>
      store_data == ($past(store_high) ? $past(sh[31:16]) : $past(sh[15:0]));
  endproperty
  a_store: assert property (p_store) else $error("store data wrong");
  c_rep: cover property (tk && op == OP_SHL && repeat_count == 8'h02);
  c_hi: cover property (tk && op == OP_ADD_HI);
  c_st: cover property (ce && store_high && store_shift == 3'h7);
endmodule // dca_datapath_asserts

/* dca_datapath_bench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dca_datapath_bench
  import dca_pkg::*;
();
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, op_valid = 1'b0, sign_ext_mode = 1'b0;
  logic status_carry = 1'b0, store_high = 1'b0, ar_load = 1'b0, arp_load = 1'b0;
  logic addr_valid = 1'b0, busy, cond_true, carry;
  dca_op_t op = OP_NOP;
  dca_cond_t cond_sel = CND_ALWAYS;
  dca_src_t ar_src = SRC_IMM;
  dca_mod_t addr_mod = MOD_NONE;
  logic [ACC_W-1:0] operand = 32'h0, prod_data = 32'h0, acc, w;
  logic [7:0] repeat_count = 8'h00;
  logic [SHF_W-1:0] store_shift = 3'h0;
  logic [HALF_W-1:0] mem_data = 16'h0, imm_data = 16'h0, store_data, addr, ar_out;
  logic [ARP_W-1:0] ar_sel = 3'h0, aux_pointer;
  int error_cnt = 0, n_checks = 0, cycles = 0;
  dca_datapath dut (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .op_valid(op_valid),
    .op(op),
    .operand(operand),
    .sign_ext_mode(sign_ext_mode),
    .status_carry(status_carry),
    .repeat_count(repeat_count),
    .busy(busy),
    .cond_sel(cond_sel),
    .cond_true(cond_true),
    .carry(carry),
    .store_high(store_high),
    .store_shift(store_shift),
    .store_data(store_data),
    .acc(acc),
    .ar_load(ar_load),
    .arp_load(arp_load),
    .ar_src(ar_src),
    .mem_data(mem_data),
    .prod_data(prod_data),
    .imm_data(imm_data),
    .ar_sel(ar_sel),
    .addr_valid(addr_valid),
    .addr_mod(addr_mod),
    .addr(addr),
    .aux_pointer(aux_pointer),
    .ar_out(ar_out)
  );
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task print_verdict;
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task do_op(input dca_op_t o, input logic [31:0] v);
    op = o;
    operand = v;
    op_valid = 1'b1;
    cyc(1);
    op_valid = 1'b0;
    cyc(1);
  endtask
  task ar_wr(input logic [2:0] s, input dca_src_t src);
    ar_sel = s;
    ar_src = src;
    ar_load = 1'b1;
    cyc(1);
    ar_load = 1'b0;
    cyc(1);
  endtask
  // ===========================================
  // scenarios
  task t_carry;
    do_op(OP_CLR_C, 32'h0);
    `CHK(carry, 1'b0)
    do_op(OP_LOAD, 32'hffff_ffff);
    do_op(OP_ADD, 32'h1);
    `CHK({carry, acc}, 33'h1_0000_0000)
    do_op(OP_ADD_C, 32'h0);
    `CHK({carry, acc}, 33'h0_0000_0001)
    do_op(OP_SUB_B, 32'h0);
    `CHK({carry, acc}, 33'h1_0000_0000)
    do_op(OP_ADD_HI, 32'h1);
    `CHK({carry, acc}, 33'h1_0001_0000)
    do_op(OP_CLR_C, 32'h0);
    do_op(OP_ADD_HI, 32'hffff);
    `CHK({carry, acc}, 33'h1_0000_0000)
    do_op(OP_SUB_HI, 32'h2);
    `CHK({carry, acc}, 33'h0_fffe_0000)
    do_op(OP_SUB_HI, 32'h1);
    `CHK({carry, acc}, 33'h0_fffd_0000)
    do_op(OP_SET_C, 32'h0);
    do_op(OP_XOR, 32'hffff_ffff);
    `CHK({carry, acc}, 33'h1_0002_ffff)
    do_op(OP_LD_ST, 32'h0);
    `CHK(carry, 1'b0)
    do_op(OP_SUB, 32'h0000_ffff);
    `CHK({carry, acc}, 33'h1_0002_0000)
    do_op(OP_OR, 32'h8000_0000);
    `CHK({carry, acc}, 33'h1_8002_0000)
    do_op(OP_SUB, 32'h9000_0000);
    `CHK({carry, acc}, 33'h0_f002_0000)
    do_op(OP_AND, 32'h3000_ffff);
    `CHK({carry, acc}, 33'h0_3000_0000)
    status_carry = 1'b1;
    do_op(OP_LD_ST, 32'h0);
    status_carry = 1'b0;
    `CHK(carry, 1'b1)
    for (int c = 0; c < 2; c++) begin
      do_op(c ? OP_SET_C : OP_CLR_C, 32'h0);
      for (int i = 0; i < 4; i++) begin
        cond_sel = dca_cond_t'(i);
        cyc(1);
        `CHK(cond_true, 1'((i == 0) || (i == 1 && c == 1) || (i == 2 && c == 0)))
      end
    end
  endtask
  task t_shift;
    sign_ext_mode = 1'b1;
    do_op(OP_LOAD, 32'h8000_0001);
    do_op(OP_SHR, 32'h0);
    `CHK({carry, acc}, 33'h1_c000_0000)
    sign_ext_mode = 1'b0;
    do_op(OP_LOAD, 32'h8000_0001);
    do_op(OP_SHR, 32'h0);
    `CHK({carry, acc}, 33'h1_4000_0000)
    sign_ext_mode = 1'b1;
    do_op(OP_LOAD, 32'h4000_0001);
    do_op(OP_SHL, 32'h0);
    `CHK({carry, acc}, 33'h0_8000_0002)
    do_op(OP_ROL, 32'h0);
    `CHK({carry, acc}, 33'h1_0000_0004)
    do_op(OP_ROL, 32'h0);
    `CHK({carry, acc}, 33'h0_0000_0009)
    do_op(OP_ROR, 32'h0);
    `CHK({carry, acc}, 33'h1_0000_0004)
    do_op(OP_ROR, 32'h0);
    `CHK({carry, acc}, 33'h0_8000_0002)
    do_op(OP_LOAD, 32'h1);
    repeat_count = 8'h02;
    op = OP_SHL;
    op_valid = 1'b1;
    cyc(1);
    `CHK(busy, 1'b1)
    op = OP_LOAD;
    operand = 32'hffff_ffff;
    cyc(1);
    op_valid = 1'b0;
    repeat_count = 8'h00;
    cyc(1);
    `CHK({busy, acc}, 33'h0_0000_0008)
  endtask
  task t_store;
    do_op(OP_LOAD, 32'h1234_5678);
    for (int i = 0; i < 16; i++) begin
      store_high = i[3];
      store_shift = i[2:0];
      cyc(1);
      w = 32'h1234_5678 << i[2:0];
      `CHK(store_data, i[3] ? w[31:16] : w[15:0])
      `CHK(acc, 32'h1234_5678)
    end
  endtask
  task t_aux;
    logic [15:0] e [4];
    dca_mod_t m [4];
    e = '{16'h5678, 16'h0033, 16'h0004, 16'h0100};
    m = '{MOD_INC, MOD_IDX, MOD_DEC, MOD_NONE};
    imm_data = 16'h0100;
    ar_wr(3'h1, SRC_IMM);
    mem_data = 16'h0004;
    ar_wr(3'h0, SRC_MEM);
    ar_wr(3'h2, SRC_ACC);
    prod_data = 32'habcd_0033;
    ar_wr(3'h3, SRC_PROD);
    for (int i = 0; i < 4; i++) begin
      imm_data = 16'((i + 2) % 4);
      mem_data = imm_data;
      ar_src = i[0] ? SRC_MEM : SRC_IMM;
      arp_load = 1'b1;
      cyc(1);
      arp_load = 1'b0;
      cyc(2);
      `CHK(aux_pointer, 3'((i + 2) % 4))
      `CHK(ar_out, e[i])
    end
    e = '{16'h0100, 16'h0101, 16'h0105, 16'h0104};
    addr_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      addr_mod = m[i];
      cyc(1);
      `CHK(addr, e[i])
    end
    addr_valid = 1'b0;
    cyc(2);
    `CHK(ar_out, 16'h0104)
  endtask
  task t_freeze;
    do_op(OP_LOAD, 32'h0000_00a5);
    do_op(OP_CLR_C, 32'h0);
    ce = 1'b0;
    do_op(OP_SET_C, 32'h0);
    do_op(OP_XOR, 32'hffff_ffff);
    `CHK({carry, acc}, 33'h0_0000_00a5)
    ce = 1'b1;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    `CHK({carry, acc, aux_pointer}, 36'h8_0000_0000)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK({carry, acc, aux_pointer}, 36'h8_0000_0000)
    t_carry();
    t_shift();
    t_store();
    t_aux();
    t_freeze();
    print_verdict();
  end
endmodule // dca_datapath_bench
bind dca_datapath dca_datapath_asserts u_chk (
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .op_valid(op_valid),
  .op(op),
  .operand(operand),
  .sign_ext_mode(sign_ext_mode),
  .repeat_count(repeat_count),
  .busy(busy),
  .cond_sel(cond_sel),
  .cond_true(cond_true),
  .carry(carry),
  .acc(acc),
  .store_high(store_high),
  .store_shift(store_shift),
  .store_data(store_data)
);

/* dca_pkg.sv */
package dca_pkg;
  // ===========================================
  // widths
  localparam int ACC_W = 32;
  localparam int HALF_W = 16;
  localparam int AR_N = 8;
  localparam int ARP_W = 3;
  localparam int SHF_W = 3;
  localparam int OP_W = 5;
  localparam logic [ARP_W-1:0] IDX_AR = 3'h0;
  localparam logic CARRY_RST = 1'b1;
  localparam logic [SHF_W-1:0] HALF_SHIFT = 3'h0;
  localparam logic [4:0] HIGH_SHIFT = 5'h10;
  localparam logic [ARP_W-1:0] ARP_RST = 3'h0;
  localparam logic [HALF_W-1:0] AR_RST = 16'h0000;

  // ===========================================
  // accumulator operations
  typedef enum logic [OP_W-1:0] {
    OP_NOP = 5'h00,
    OP_LOAD = 5'h01,
    OP_ADD = 5'h02,
    OP_SUB = 5'h03,
    OP_ADD_C = 5'h04,
    OP_SUB_B = 5'h05,
    OP_ADD_HI = 5'h06,
    OP_SUB_HI = 5'h07,
    OP_AND = 5'h08,
    OP_OR = 5'h09,
    OP_XOR = 5'h0a,
    OP_SHL = 5'h0b,
    OP_SHR = 5'h0c,
    OP_ROL = 5'h0d,
    OP_ROR = 5'h0e,
    OP_SET_C = 5'h0f,
    OP_CLR_C = 5'h10,
    OP_LD_ST = 5'h11
  } dca_op_t;

  // ===========================================
  // carry conditions
  typedef enum logic [1:0] {
    CND_ALWAYS = 2'h0,
    CND_CARRY = 2'h1,
    CND_NO_CARRY = 2'h2,
    CND_NEVER = 2'h3
  } dca_cond_t;

  // ===========================================
  // aux register sources and post-modify
  typedef enum logic [1:0] {
    SRC_MEM = 2'h0,
    SRC_ACC = 2'h1,
    SRC_PROD = 2'h2,
    SRC_IMM = 2'h3
  } dca_src_t;

  typedef enum logic [1:0] {
    MOD_NONE = 2'h0,
    MOD_INC = 2'h1,
    MOD_DEC = 2'h2,
    MOD_IDX = 2'h3
  } dca_mod_t;
endpackage
